// ---- regdec_defines.svh ----
`ifndef REGDEC_DEFINES_SVH
`define REGDEC_DEFINES_SVH

// ----------------------------------------
// Global operation control offsets
// ----------------------------------------
`define OFF_FIXED_ID        16'h0000
`define OFF_CHIP_ID_UPPER   16'h0001
`define OFF_CHIP_ID_LOWER   16'h0002
`define OFF_REV_SOFT_RST    16'h0003
`define OFF_PWR_EVT_CTRL    16'h0006
`define OFF_GLB_INT_STATUS  16'h0010
`define OFF_GLB_INT_MASK    16'h0014

// ----------------------------------------
// Address fields
// ----------------------------------------
`define ADDR_PORT_MSB       15
`define ADDR_PORT_LSB       12
`define ADDR_PAGE_MSB       11
`define ADDR_PAGE_LSB       8
`define ADDR_INDEX_MSB      7
`define ADDR_INDEX_LSB      0
`define ADDR_TOP_BIT        15

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SOFT_RST_BIT        0
`define REV_MSB             7
`define REV_LSB             4
`define PWR_EVT_EN_BIT      1
`define PWR_EVT_POL_BIT     0
`define INT_LOOKUP_BIT      31
`define INT_TRIGGER_BIT     30
`define INT_TIMEOUT_MSB     29
`define SOFT_RST_RESET      1'b0
`define PWR_EVT_CTRL_RESET  2'h0
`define INT_MASK_RESET      32'h0000_0000

// ----------------------------------------
// Decode limits
// ----------------------------------------
`define GLOBAL_PORT         4'h0
`define LAST_PORT           4'h7
`define LAST_GLOBAL_PAGE    4'h5
`define PAGE_PHY            4'h1
`define PAGE_MAC_IF         4'h3

`endif

// ---- regdec_pkg.sv ----
package regdec_pkg;

    typedef enum logic [3:0] {
        GRP_OPERATION = 4'h0,
        GRP_IO        = 4'h1,
        GRP_PHY_CTL   = 4'h2,
        GRP_SWITCH    = 4'h3,
        GRP_LOOKUP    = 4'h4,
        GRP_PTP       = 4'h5,
        GRP_PORT_PHY  = 4'h6,
        GRP_PORT_MAC  = 4'h7,
        GRP_PORT_OTH  = 4'h8,
        GRP_RESERVED  = 4'h9,
        GRP_BAD_PORT  = 4'hA
    } group_e;

    typedef struct packed {
        logic [3:0] port;
        logic [3:0] page;
        logic [7:0] index;
    } reg_addr_s;

    typedef struct packed {
        group_e     group;
        logic       is_global;
        logic       reserved;
        logic [3:0] port;
        logic [7:0] index;
    } decode_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       from_mdio;
        logic [15:0] addr;
        logic [7:0] wdata;
    } byte_req_s;

    typedef enum logic [1:0] {
        OUT_IDLE   = 2'b00,
        OUT_ACTIVE = 2'b01
    } pin_state_e;

endpackage

// ---- addr_decoder.sv ----
`timescale 1ns/100ps
`include "regdec_defines.svh"

module addr_decoder
    import regdec_pkg::*;
(
    input  wire logic [15:0] addr,
    output decode_s          dec
);

    reg_addr_s fields;

    always_comb begin
        fields = reg_addr_s'(addr);
        dec           = '0;
        dec.port      = fields.port;
        dec.index     = fields.index;
        dec.is_global = (fields.port == `GLOBAL_PORT);
        dec.group     = GRP_RESERVED;
        dec.reserved  = 1'b1;
        if (dec.is_global) begin
            if (fields.page <= `LAST_GLOBAL_PAGE) begin
                dec.group    = group_e'(fields.page);
                dec.reserved = 1'b0;
            end
        end else if (fields.port <= `LAST_PORT) begin
            unique case (fields.page)
                4'h1: begin
                    dec.group    = GRP_PORT_PHY;
                    dec.reserved = 1'b0;
                end
                4'h3: begin
                    dec.group    = GRP_PORT_MAC;
                    dec.reserved = 1'b0;
                end
                4'h2, 4'h7, 4'hD, 4'hE, 4'hF: begin
                    dec.group    = GRP_RESERVED;
                    dec.reserved = 1'b1;
                end
                default: begin
                    dec.group    = GRP_PORT_OTH;
                    dec.reserved = 1'b0;
                end
            endcase
        end else begin
            dec.group = GRP_BAD_PORT;
        end
    end

endmodule

// ---- power_event_out.sv ----
`timescale 1ns/100ps
`include "regdec_defines.svh"

module power_event_out
    import regdec_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic enable,
    input  wire logic active_high,
    input  wire logic request,
    output logic      pin_out,
    output logic      pin_oe_n
);

    pin_state_e state_reg;
    pin_state_e state_next;

    always_comb begin
        state_next = (enable && request) ? OUT_ACTIVE : OUT_IDLE;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= OUT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered so the pin never glitches on decode changes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out  <= 1'b1;
            pin_oe_n <= 1'b1;
        end else begin
            pin_oe_n <= ~enable;
            unique case (state_next)
                OUT_ACTIVE: pin_out <= active_high;
                OUT_IDLE:   pin_out <= ~active_high;
                default:    pin_out <= ~active_high;
            endcase
        end
    end

endmodule

// ---- switch_global_regs.sv ----
`timescale 1ns/100ps
`include "regdec_defines.svh"

// How it works
// - Address splits into 4-bit port, 4-bit page, 8-bit index.
// - Ports 1 to 7 address port space; port zero is global.
// - Every register byte is accessed alone, in any order.
// - Wide registers are big-endian: MSB at lowest address.
// - All management paths move one byte per access.
// - Accesses arriving over MDIO never touch switch registers.
// - Global pages 0 to 5 decode to groups; 6 to F reserved.
// - Port page 1 is PHY, 3 is MAC interface; 2,7,D-F reserved.
// - Fixed byte at 0, 16-bit chip identifier at 1 and 2.
// - Offset 3 holds revision in bits 7:4; bits 3:1 read-only.
// - Bit 0 of offset 3 holds datapath in reset; not self-clearing.
// - Bit 1 at offset 6 enables power-event pin; resets disabled.
// - Bit 0 at offset 6 picks pin polarity; zero is active low.
// - Status bit 31 lookup engine, bit 30 trigger/timestamp unit.
// - Status bits 29:0 report bus access timeouts, reset zero.
// - A status bit requests an interrupt only when unmasked.
// - Mask at 0x0014: zero enables, one disables, resets zero.

module switch_global_regs
    import regdec_pkg::*;
#(
    parameter logic [7:0] FIXED_ID_VALUE = 8'hA5, // Arbitrary value
    parameter logic [15:0] CHIP_ID_VALUE = 16'h1234, // Arbitrary value
    parameter logic [3:0] REVISION_VALUE = 4'h1, // Arbitrary value
    parameter int         TIMEOUT_SRCS   = 30
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_from_mdio,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic [7:0]       rsp_rdata,
    output logic             rsp_valid,
    output logic             rsp_reserved,
    output logic             rsp_port_access,
    output logic [3:0]       rsp_group,
    input  wire logic        lookup_engine_irq,
    input  wire logic        trigger_unit_irq,
    input  wire logic [TIMEOUT_SRCS-1:0] timeout_irq,
    output logic             datapath_reset,
    output logic             power_event_pin_out,
    output logic             power_event_pin_oe_n
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (TIMEOUT_SRCS != 30) begin : g_bad_width
        $error("timeout source count must be 30");
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    byte_req_s req;
    decode_s   dec;
    logic      op_space;
    logic      wr_en;
    logic      rd_en;

    assign req = '{valid: req_valid, write: req_write,
                   from_mdio: req_from_mdio, addr: req_addr,
                   wdata: req_wdata};

    addr_decoder u_dec (
        .addr (req.addr),
        .dec  (dec)
    );

    assign op_space = dec.is_global && (dec.group == GRP_OPERATION);
    assign wr_en = req.valid && req.write && !req.from_mdio && op_space;
    assign rd_en = req.valid && !req.write && !req.from_mdio;

    // ----------------------------------------
    // Writable state
    // ----------------------------------------
    logic        soft_rst_reg;
    logic [1:0]  pwr_evt_ctrl_reg;
    logic [31:0] int_mask_reg;
    logic [31:0] int_status_reg;
    logic [31:0] int_status_next;
    logic [1:0]  mask_lane;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            soft_rst_reg <= `SOFT_RST_RESET;
        end else if (wr_en && dec.index == 8'(`OFF_REV_SOFT_RST)) begin
            soft_rst_reg <= req.wdata[`SOFT_RST_BIT];
        end
    end

    // Register contents survive the soft reset by design
    assign datapath_reset = soft_rst_reg;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_evt_ctrl_reg <= `PWR_EVT_CTRL_RESET;
        end else if (wr_en && dec.index == 8'(`OFF_PWR_EVT_CTRL)) begin
            pwr_evt_ctrl_reg <= req.wdata[1:0];
        end
    end

    assign mask_lane = 2'(dec.index - 8'(`OFF_GLB_INT_MASK));

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_mask_reg <= `INT_MASK_RESET;
        end else if (wr_en && dec.index[7:2] == 6'h05) begin
            int_mask_reg[8*(3-mask_lane) +: 8] <= req.wdata;
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    // Source levels
    // Timeout bits
    // Reflects source levels; sources clear at their own registers
    always_comb begin
        int_status_next = '0;
        int_status_next[`INT_LOOKUP_BIT]  = lookup_engine_irq;
        int_status_next[`INT_TRIGGER_BIT] = trigger_unit_irq;
        int_status_next[`INT_TIMEOUT_MSB:0] = timeout_irq;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_status_reg <= '0;
        end else begin
            int_status_reg <= int_status_next;
        end
    end

    logic int_request;
    assign int_request = |(int_status_reg & ~int_mask_reg);

    power_event_out u_pin (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .enable      (pwr_evt_ctrl_reg[`PWR_EVT_EN_BIT]),
        .active_high (pwr_evt_ctrl_reg[`PWR_EVT_POL_BIT]),
        .request     (int_request),
        .pin_out     (power_event_pin_out),
        .pin_oe_n    (power_event_pin_oe_n)
    );

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rd_byte;
    logic [1:0] lane;

    assign lane = dec.index[1:0];

    always_comb begin
        rd_byte = 8'h00;
        if (op_space) begin
            unique case (dec.index)
                8'h00: rd_byte = FIXED_ID_VALUE;
                8'h01: rd_byte = CHIP_ID_VALUE[15:8];
                8'h02: rd_byte = CHIP_ID_VALUE[7:0];
                8'h03: rd_byte = {REVISION_VALUE, 3'h0, soft_rst_reg};
                8'h06: rd_byte = {6'h00, pwr_evt_ctrl_reg};
                8'h10, 8'h11, 8'h12, 8'h13:
                    rd_byte = int_status_reg[8*(3-lane) +: 8];
                8'h14, 8'h15, 8'h16, 8'h17:
                    rd_byte = int_mask_reg[8*(3-lane) +: 8];
                default: rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_rdata       <= 8'h00;
            rsp_valid       <= 1'b0;
            rsp_reserved    <= 1'b0;
            rsp_port_access <= 1'b0;
            rsp_group       <= 4'h0;
        end else begin
            rsp_valid <= req.valid && !req.from_mdio;
            if (req.valid && !req.from_mdio) begin
                rsp_rdata       <= rd_en ? rd_byte : 8'h00;
                rsp_reserved    <= dec.reserved;
                rsp_port_access <= !dec.is_global;
                rsp_group       <= dec.group;
            end
        end
    end

endmodule

// ---- regdec_properties.sv ----
`timescale 1ns/100ps
module regdec_properties
    import regdec_pkg::*;
#(
    parameter logic [15:0] CHIP_ID_VALUE = 16'h1234
)
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_from_mdio,
    input wire logic [15:0] req_addr,
    input wire logic [7:0]  rsp_rdata,
    input wire logic        rsp_valid,
    input wire logic        rsp_reserved,
    input wire logic        rsp_port_access,
    input wire logic [3:0]  rsp_group,
    input wire logic        datapath_reset,
    input wire logic        power_event_pin_out,
    input wire logic        power_event_pin_oe_n
);
    // ------
    // Checks
    // ------
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic take;
    assign take = req_valid && !req_from_mdio;
    chk_answer_next:
    assert property (take |=> rsp_valid) else $error("no answer");
    chk_mdio_ignored:
    assert property (req_valid && req_from_mdio |=> !rsp_valid)
        else $error("mdio answered");
    chk_port_flag:
    assert property (take |=>
        rsp_port_access == ($past(req_addr[15:12]) != 4'h0))
        else $error("port flag wrong");
    chk_global_group:
    assert property (take && req_addr[15:12] == 4'h0 &&
        req_addr[11:8] <= 4'h5 |=>
        !rsp_reserved && rsp_group == $past(req_addr[11:8]))
        else $error("global group wrong");
    chk_global_reserved:
    assert property (take && req_addr[15:12] == 4'h0 &&
        req_addr[11:8] > 4'h5 |=> rsp_reserved && rsp_group == GRP_RESERVED)
        else $error("reserved page missed");
    chk_port_phy_page:
    assert property (take && req_addr[15:12] != 4'h0 && !req_addr[15] &&
        req_addr[11:8] == 4'h1 |=> rsp_group == GRP_PORT_PHY && !rsp_reserved)
        else $error("port phy page wrong");
    chk_chip_id_order:
    assert property (take && !req_write &&
        (req_addr == 16'h0001 || req_addr == 16'h0002) |=>
        rsp_rdata == ($past(req_addr[1]) ? CHIP_ID_VALUE[7:0]
                                         : CHIP_ID_VALUE[15:8]))
        else $error("chip id byte wrong");
    chk_soft_reset_held:
    assert property (!(take && req_write && req_addr == 16'h0003) |=>
        $stable(datapath_reset)) else $error("soft reset moved");
    cover property (take && req_addr[11:8] > 4'h5);
    cover property ($rose(datapath_reset));
    cover property (!power_event_pin_oe_n && power_event_pin_out);
endmodule

// ---- host_model.sv ----
`timescale 1ns/100ps
module host_model (
    input wire logic  core_clk,
    input wire logic [7:0] rsp_rdata,
    output logic      req_valid,
    output logic      req_write,
    output logic      req_from_mdio,
    output logic [15:0] req_addr,
    output logic [7:0] req_wdata
);
    // -----------
    // Byte access
    // -----------
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_from_mdio = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
    end
    task automatic acc(input logic w, input logic m, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_from_mdio = m;
        req_addr = {1'b0, a[14:0]};
        req_wdata = d;
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        q = rsp_rdata;
        // Released lines scrambled, no stale value
        req_addr = ~req_addr;
        req_wdata = ~req_wdata;
    endtask
    task automatic rmw(input logic [15:0] a, input logic [7:0] b);
        logic [7:0] q;
        acc(1'b0, 1'b0, a, 8'h00, q);
        acc(1'b1, 1'b0, a, q | b, q);
    endtask
endmodule

// ---- tb_switch_global_regs.sv ----
`timescale 1ns/100ps
module tb_switch_global_regs;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        req_valid, req_write, req_from_mdio;
    logic [15:0] req_addr;
    logic [7:0]  req_wdata, rsp_rdata, q;
    logic        rsp_valid, rsp_reserved, rsp_port_access;
    logic [3:0]  rsp_group;
    logic        lookup_engine_irq, trigger_unit_irq, datapath_reset;
    logic [29:0] timeout_irq;
    logic        power_event_pin_out, power_event_pin_oe_n;
    int          num_errors = 0;
    int          checked = 0;

    always #5 core_clk = ~core_clk;
    switch_global_regs dut_u (
        .core_clk             (core_clk),
        .sys_rst              (sys_rst),
        .req_valid            (req_valid),
        .req_write            (req_write),
        .req_from_mdio        (req_from_mdio),
        .req_addr             (req_addr),
        .req_wdata            (req_wdata),
        .rsp_rdata            (rsp_rdata),
        .rsp_valid            (rsp_valid),
        .rsp_reserved         (rsp_reserved),
        .rsp_port_access      (rsp_port_access),
        .rsp_group            (rsp_group),
        .lookup_engine_irq    (lookup_engine_irq),
        .trigger_unit_irq     (trigger_unit_irq),
        .timeout_irq          (timeout_irq),
        .datapath_reset       (datapath_reset),
        .power_event_pin_out  (power_event_pin_out),
        .power_event_pin_oe_n (power_event_pin_oe_n)
    );
    host_model host_u (
        .core_clk      (core_clk),
        .rsp_rdata     (rsp_rdata),
        .req_valid     (req_valid),
        .req_write     (req_write),
        .req_from_mdio (req_from_mdio),
        .req_addr      (req_addr),
        .req_wdata     (req_wdata)
    );

    // -------
    // Helpers
    // -------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp);
        host_u.acc(1'b0, 1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        host_u.acc(1'b1, 1'b0, a, d, q);
    endtask
    // Status to pin takes two edges
    task pin(input logic [7:0] exp);
        repeat (2) @(posedge core_clk);
        #1;
        chk({6'h0, power_event_pin_oe_n, power_event_pin_out}, exp);
    endtask
    task dec(input logic [15:0] a, input logic [7:0] exp);
        rd(a, 8'h00);
        chk({1'b0, rsp_valid, rsp_reserved, rsp_port_access, rsp_group},
            exp);
    endtask
    task give_verdict;
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        give_verdict;
    end

    // -----
    // Tests
    // -----
    initial begin
        lookup_engine_irq = 1'b0;
        trigger_unit_irq = 1'b0;
        timeout_irq = '0;
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rd(16'h0000, 8'hA5);
        rd(16'h0001, 8'h12);
        rd(16'h0002, 8'h34);
        rd(16'h0003, 8'h10);
        rd(16'h0006, 8'h00);
        for (int i = 0; i < 8; i++) rd(16'h0010 + i[15:0], 8'h00);
        pin(8'h03);
        host_u.rmw(16'h0003, 8'h01);
        rd(16'h0003, 8'h11);
        chk({7'h0, datapath_reset}, 8'h01);
        wr(16'h0003, 8'h10);
        host_u.acc(1'b1, 1'b1, 16'h0003, 8'h01, q);
        chk({7'h0, rsp_valid}, 8'h00);
        rd(16'h0003, 8'h10);
        chk({7'h0, datapath_reset}, 8'h00);
        lookup_engine_irq = 1'b1;
        timeout_irq[0] = 1'b1;
        rd(16'h0010, 8'h80);
        rd(16'h0013, 8'h01);
        trigger_unit_irq = 1'b1;
        rd(16'h0010, 8'hC0);
        host_u.rmw(16'h0006, 8'h02);
        pin(8'h00);
        wr(16'h0006, 8'h03);
        pin(8'h01);
        for (int i = 3; i >= 0; i--) wr(16'h0014 + i[15:0], 8'hFF);
        pin(8'h00);
        rd(16'h0014, 8'hFF);
        wr(16'h0017, 8'hFE);
        pin(8'h01);
        dec(16'h0400, 8'h44);
        dec(16'h0600, 8'h69);
        dec(16'h3155, 8'h56);
        dec(16'h7200, 8'h79);
        dec(16'h5D00, 8'h79);
        give_verdict;
    end
endmodule

bind switch_global_regs regdec_properties #(
    .CHIP_ID_VALUE(CHIP_ID_VALUE)
) chk_u (
    .core_clk             (core_clk),
    .sys_rst              (sys_rst),
    .req_valid            (req_valid),
    .req_write            (req_write),
    .req_from_mdio        (req_from_mdio),
    .req_addr             (req_addr),
    .rsp_rdata            (rsp_rdata),
    .rsp_valid            (rsp_valid),
    .rsp_reserved         (rsp_reserved),
    .rsp_port_access      (rsp_port_access),
    .rsp_group            (rsp_group),
    .datapath_reset       (datapath_reset),
    .power_event_pin_out  (power_event_pin_out),
    .power_event_pin_oe_n (power_event_pin_oe_n)
);
